// [include/dsr_pkg.sv]
// Package of constants for the decimator status register block
package dsr_pkg;
	// ************************************************************
	// Status word layout
	// ************************************************************
	localparam int STATUS_W = 24;
	localparam int BIT_ERROR = 23;
	localparam int BIT_OVERWRITE = 22;
	localparam int BIT_MOD_FLAG = 21;
	localparam int BIT_ACC_SAT = 19;
	localparam int BIT_SAMPLE_READY = 18;
	localparam int BIT_SETTLED = 17;
	localparam int BIT_RANGE = 16;
	localparam int BIT_POWER_DOWN = 11;
	localparam int BIT_TEST_INPUT = 10;
	localparam int BIT_BW_HI = 8;
	localparam int BIT_BW_LO = 6;
	localparam int BIT_GAIN_HI = 4;
	localparam int BIT_GAIN_LO = 0;
	localparam int BW_W = 3;
	localparam int GAIN_W = 5;
	localparam int CFG_W = 10;
	// ************************************************************
	// Reset values and output coding
	// ************************************************************
	localparam logic RST_FLAG = 1'b0;
	localparam logic RST_ERROR_N = 1'b1;
	localparam logic [23:0] RST_WORD = 24'h000000;
	localparam logic [23:0] FS_POS = 24'h7fffff;
	localparam logic [23:0] FS_NEG = 24'h800000;
	localparam logic [23:0] RANGE_HI = 24'h5fffff;
	localparam logic [23:0] RANGE_LO = 24'ha00000;
	// ************************************************************
	// Counts
	// ************************************************************
	localparam int RANGE_RUN = 4;
	localparam int READ_BITS = 24;
	typedef enum logic {DSR_RD_IDLE, DSR_RD_SHIFT} dsr_rd_type;
endpackage

// [hw/dsr_range_detect.sv]
// Detector for runs of filter outputs beyond the specified code range
`timescale 1ns/10ps
module dsr_range_detect #(
	parameter int RUN = dsr_pkg::RANGE_RUN
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Clipped filter output
	input wire logic i_valid,
	input wire logic [23:0] i_word,
	// Run detected, high the cycle after each valid output that completes or extends a run
	output logic o_hit
);
	logic [2:0] above_run;
	logic [2:0] below_run;
	logic is_above;
	logic is_below;

	assign is_above = $signed(i_word) > $signed(dsr_pkg::RANGE_HI);
	assign is_below = $signed(i_word) < $signed(dsr_pkg::RANGE_LO);

	// Runs saturate at RUN so a long excursion keeps reporting
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			above_run <= 3'h0;
			below_run <= 3'h0;
		end else if (i_valid) begin
			above_run <= is_above ? ((above_run == 3'(RUN)) ? above_run : above_run + 3'h1) : 3'h0;
			below_run <= is_below ? ((below_run == 3'(RUN)) ? below_run : below_run + 3'h1) : 3'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_hit <= 1'b0;
		end else begin
			o_hit <= i_valid && ((is_above && above_run >= 3'(RUN - 1)) ||
				(is_below && below_run >= 3'(RUN - 1)));
		end
	end
endmodule

// [hw/dsr_status.sv]
// Status register of the decimation filter with clipping and serial readout
//
// Operation
// - A 24-bit status word holds error flags and reads back the active configuration.
// - The summary error bit 23 is the OR of overwrite, modulator flag and accumulator bits, except that reset clears it while the modulator flag holds.
// - Summary and individual error bits clear after a completed status read; all but the modulator flag also clear on reset.
// - The error pin is always the inverse of the summary error bit.
// - Overwrite sets when a result is loaded while a data read is under way.
// - The modulator flag bit takes the synchronised modulator flag pin level on each clock edge while the filter is settled and not powered down.
// - The modulator flag bit holds during power-down and during reset.
// - Filter overflow or underflow sets the accumulator bit and clips the output to full scale.
// - The settled bit clears on reset, during power-down and at power-down exit, and marks accurate data.
// - The settled bit also clears on sync, pin configuration change and modulator flag set.
// - While not settled, overwrite, modulator flag, accumulator and range bits hold except that a completed read clears them.
// - The range bit sets after four outputs in a row above +6291455 or below -6291456.
// - Flags sit at bits 23,22,21,19,18,17,16 and reset to zero except the modulator flag.
// - Bits 11, 10, 8-6 and 4-0 read back configuration; unused bits read as zero.
// - Power-down keeps register contents and leaves the serial readout usable.
`timescale 1ns/10ps
module dsr_status #(
	parameter int ACC_W = 26
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Modulator flag pin, asynchronous
	input wire logic i_modulator_flag,
	// Filter datapath
	input wire logic i_filter_valid,
	input wire logic [ACC_W-1:0] i_filter_word,
	input wire logic i_settle_done,
	input wire logic i_sync,
	// Output data register handshake
	input wire logic i_result_load,
	input wire logic i_data_read_active,
	input wire logic i_sample_ready,
	// Active configuration
	input wire logic i_cfg_from_pins,
	input wire logic i_power_down_ctl,
	input wire logic i_test_input_select,
	input wire logic [2:0] i_bandwidth_code,
	input wire logic [4:0] i_gain_input_select,
	// Status read strobes from the serial interface
	input wire logic i_status_read_start,
	input wire logic i_status_shift,
	input wire logic i_status_read_abort,
	// Outputs
	output logic [23:0] o_result_word,
	output logic o_result_valid,
	output logic [23:0] o_status_word,
	output logic o_status_sdo,
	output logic o_status_done,
	output logic o_error_n
);
	// ************************************************************
	// State
	// ************************************************************
	logic modulator_flag_meta;
	logic modulator_flag_pin;
	logic overwrite_flag;
	// Power-up value; after that a reset holds whatever the flag last sampled
	logic modulator_flag = 1'b0;
	logic accumulator_saturation;
	logic out_of_range_flag;
	logic filter_settled;
	logic error_flag;
	logic sample_ready;
	logic [dsr_pkg::CFG_W-1:0] cfg_q;
	logic pd_q;
	logic range_hit;
	logic sat_event;
	logic [ACC_W-24:0] top_bits;
	logic read_done;
	logic [23:0] shift_reg;
	logic [4:0] shift_cnt;
	dsr_pkg::dsr_rd_type rd_state;
	logic next_overwrite;
	logic next_modulator;
	logic next_acc;
	logic [dsr_pkg::CFG_W-1:0] cfg_now;

	assign cfg_now = {i_power_down_ctl, i_test_input_select, i_bandwidth_code,
		i_gain_input_select};
	assign top_bits = i_filter_word[ACC_W-1:23];
	assign sat_event = i_filter_valid && !((&top_bits) || !(|top_bits));

	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	always_ff @(posedge i_clk) begin
		modulator_flag_meta <= i_modulator_flag;
		modulator_flag_pin <= modulator_flag_meta;
	end

	// ************************************************************
	// Clipping of the filter output
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_result_word <= dsr_pkg::RST_WORD;
			o_result_valid <= 1'b0;
		end else begin
			o_result_valid <= i_filter_valid;
			if (i_filter_valid) begin
				if (sat_event) begin
					o_result_word <= i_filter_word[ACC_W-1] ? dsr_pkg::FS_NEG : dsr_pkg::FS_POS;
				end else begin
					o_result_word <= i_filter_word[23:0];
				end
			end
		end
	end

	dsr_range_detect #(
		.RUN(dsr_pkg::RANGE_RUN)
	) u_range (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_valid(o_result_valid),
		.i_word(o_result_word),
		.o_hit(range_hit)
	);

	// ************************************************************
	// Error flags
	// ************************************************************
	// New events win over the read clear; a not-settled filter freezes them
	always_comb begin
		next_overwrite = overwrite_flag;
		next_modulator = modulator_flag;
		next_acc = accumulator_saturation;
		if (read_done) begin
			next_overwrite = 1'b0;
			next_modulator = 1'b0;
			next_acc = 1'b0;
		end
		if (filter_settled) begin
			if (i_result_load && i_data_read_active) begin
				next_overwrite = 1'b1;
			end
			if (!pd_q) begin
				next_modulator = modulator_flag_pin;
			end
			if (sat_event) begin
				next_acc = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			overwrite_flag <= dsr_pkg::RST_FLAG;
			accumulator_saturation <= dsr_pkg::RST_FLAG;
			error_flag <= dsr_pkg::RST_FLAG;
			o_error_n <= dsr_pkg::RST_ERROR_N;
		end else begin
			overwrite_flag <= next_overwrite;
			accumulator_saturation <= next_acc;
			error_flag <= next_overwrite | next_modulator | next_acc;
			o_error_n <= ~(next_overwrite | next_modulator | next_acc);
		end
	end

	// Reset holds the flag, as does power-down
	always_ff @(posedge i_clk) begin
		if (!i_sys_rst) begin
			modulator_flag <= next_modulator;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			out_of_range_flag <= dsr_pkg::RST_FLAG;
		end else if (filter_settled && range_hit) begin
			out_of_range_flag <= 1'b1;
		end else if (read_done) begin
			out_of_range_flag <= 1'b0;
		end
	end

	// ************************************************************
	// Settled flag and configuration readback
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cfg_q <= '0;
			pd_q <= 1'b0;
			sample_ready <= 1'b0;
		end else begin
			cfg_q <= cfg_now;
			pd_q <= i_power_down_ctl;
			sample_ready <= i_sample_ready;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			filter_settled <= dsr_pkg::RST_FLAG;
		end else if ((pd_q && !i_power_down_ctl) || i_power_down_ctl) begin
			filter_settled <= 1'b0;
		end else if (i_sync || (i_cfg_from_pins && cfg_now[8:0] != cfg_q[8:0]) ||
			(next_modulator && !modulator_flag)) begin
			filter_settled <= 1'b0;
		end else if (i_settle_done) begin
			filter_settled <= 1'b1;
		end
	end

	assign o_status_word = {error_flag, overwrite_flag, modulator_flag, 1'b0,
		accumulator_saturation, sample_ready, filter_settled, out_of_range_flag,
		4'h0, cfg_q[9:8], 1'b0, cfg_q[7:5], 1'b0, cfg_q[4:0]};

	// ************************************************************
	// Serial readout of the status word
	// ************************************************************
	assign read_done = o_status_done;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rd_state <= dsr_pkg::DSR_RD_IDLE;
			shift_reg <= '0;
			shift_cnt <= 5'h00;
			o_status_sdo <= 1'b0;
			o_status_done <= 1'b0;
		end else begin
			o_status_done <= 1'b0;
			case (rd_state)
				dsr_pkg::DSR_RD_IDLE: begin
					if (i_status_read_start) begin
						shift_reg <= o_status_word;
						o_status_sdo <= o_status_word[23];
						shift_cnt <= 5'h00;
						rd_state <= dsr_pkg::DSR_RD_SHIFT;
					end
				end
				default: begin
					if (i_status_read_abort) begin
						rd_state <= dsr_pkg::DSR_RD_IDLE;
					end else if (i_status_shift) begin
						shift_reg <= {shift_reg[22:0], 1'b0};
						o_status_sdo <= shift_reg[22];
						shift_cnt <= shift_cnt + 5'h01;
						if (shift_cnt == 5'(dsr_pkg::READ_BITS - 1)) begin
							o_status_done <= 1'b1;
							rd_state <= dsr_pkg::DSR_RD_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_error_or: assert property (@(posedge i_clk) disable iff (i_sys_rst) !$past(i_sys_rst) |->
		error_flag == (overwrite_flag | modulator_flag | accumulator_saturation))
		else $error("summary error differs from OR of error bits");
	a_error_pin: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_error_n == !error_flag)
		else $error("error pin not inverse of summary bit");
	a_read_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_status_done && !(filter_settled && i_result_load && i_data_read_active)
		|=> !overwrite_flag)
		else $error("overwrite not cleared after completed read");
	a_overwrite_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		filter_settled && i_result_load && i_data_read_active |=> overwrite_flag)
		else $error("overwrite not set");
	a_frozen: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!filter_settled && !o_status_done |=> $stable(accumulator_saturation) &&
		$stable(out_of_range_flag) && $stable(modulator_flag))
		else $error("flags changed while filter not settled");
	a_modulator_flag_hold: assert property (@(posedge i_clk)
		i_sys_rst |=> $stable(modulator_flag))
		else $error("modulator flag changed during reset");
	a_clip_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sat_event && !i_filter_word[ACC_W-1] |=> o_result_word == dsr_pkg::FS_POS &&
		(accumulator_saturation || !$past(filter_settled)))
		else $error("positive overflow not clipped");
	a_settle_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_sync |=> !filter_settled)
		else $error("sync did not clear settled");
	a_read_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_status_done |-> $past(shift_cnt) == 5'(dsr_pkg::READ_BITS - 1))
		else $error("read completed early");
	a_cfg_back: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		##1 o_status_word[11] == $past(i_power_down_ctl) && o_status_word[20] == 1'b0)
		else $error("configuration readback wrong");
	c_read_done: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_status_done);
	c_overwrite: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(overwrite_flag));
	c_range: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(out_of_range_flag));
	c_abort: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		rd_state == dsr_pkg::DSR_RD_SHIFT && i_status_read_abort);
endmodule

// [test/dsr_host_model.sv]
// Host that reads the status word serially, MSB first
`timescale 1ns/10ps
module dsr_host_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Control from bench; i_stop_at nonzero aborts after that many shifts
	input wire logic i_go,
	input wire logic [4:0] i_stop_at,
	input wire logic i_sdo,
	// Strobes to the device and captured word
	output logic o_start,
	output logic o_shift,
	output logic o_abort,
	output logic [23:0] o_word,
	output logic o_busy
);
	// ************************************************************
	// Read sequencer
	// ************************************************************
	logic [5:0] cnt;
	always @(posedge i_clk) begin
		o_start <= 1'b0;
		o_abort <= 1'b0;
		if (i_sys_rst) begin
			o_shift <= 1'b0;
			o_busy <= 1'b0;
			cnt <= 6'h00;
			o_word <= 24'h000000;
		end else if (!o_busy) begin
			o_shift <= 1'b0;
			if (i_go) begin
				o_start <= 1'b1;
				o_busy <= 1'b1;
				cnt <= 6'h00;
			end
		end else begin
			// Each bit is taken at the edge that also takes its shift
			cnt <= cnt + 6'h01;
			if (cnt >= 6'h01)
				o_word <= {o_word[22:0], i_sdo};
			o_shift <= (cnt < 6'h18);
			if (cnt == 6'h18)
				o_busy <= 1'b0;
			if (i_stop_at != 5'h00 && cnt == {1'b0, i_stop_at}) begin
				o_abort <= 1'b1;
				o_shift <= 1'b0;
				o_busy <= 1'b0;
			end
		end
	end
endmodule

// [test/test_decimator_status_register.sv]
// Self-checking bench of the decimator status register
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module test_decimator_status_register;
	// ************************************************************
	// Signals
	// ************************************************************
	logic clk = 1'b0, rst = 1'b1, mf = 1'b0, fv = 1'b0, sd = 1'b0, sy = 1'b0;
	logic rl = 1'b0, ra = 1'b0, sr = 1'b0, cp = 1'b1, pd = 1'b0, ts = 1'b1;
	logic [25:0] fw = 26'h0000000;
	logic [2:0] bw = 3'h5;
	logic [4:0] gs = 5'h15, stop = 5'h00;
	logic go = 1'b0, ss, sh, ab, so, dn, rv, en, hb;
	logic [23:0] rw, sw, hw;
	int error_cnt = 0, num_checks = 0, cyc = 0, n;
	always #2 clk = ~clk;
	dsr_status dut (.i_clk(clk), .i_sys_rst(rst), .i_modulator_flag(mf), .i_filter_valid(fv),
		.i_filter_word(fw), .i_settle_done(sd), .i_sync(sy), .i_result_load(rl),
		.i_data_read_active(ra), .i_sample_ready(sr), .i_cfg_from_pins(cp),
		.i_power_down_ctl(pd), .i_test_input_select(ts), .i_bandwidth_code(bw),
		.i_gain_input_select(gs), .i_status_read_start(ss), .i_status_shift(sh),
		.i_status_read_abort(ab), .o_result_word(rw), .o_result_valid(rv),
		.o_status_word(sw), .o_status_sdo(so), .o_status_done(dn), .o_error_n(en));
	dsr_host_model host (.i_clk(clk), .i_sys_rst(rst), .i_go(go), .i_stop_at(stop),
		.i_sdo(so), .o_start(ss), .o_shift(sh), .o_abort(ab), .o_word(hw), .o_busy(hb));
	// ************************************************************
	// Tasks
	// ************************************************************
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test;
		end
	end
	task w(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Full read, or aborted after s shifts; n counts edges until done
	task rd(input logic [4:0] s);
		w(1);
		go <= 1'b1;
		stop <= s;
		n = 0;
		repeat (40) begin
			w(1);
			go <= 1'b0;
			#1;
			n++;
			if (dn === 1'b1)
				break;
		end
		`CHK(n, (s == 5'h00) ? 26 : 40)
	endtask
	task settle;
		w(1); sd <= 1'b1;
		w(1); sd <= 1'b0;
		w(2); #1;
	endtask
	task fp(input logic [25:0] v);
		w(1); fv <= 1'b1; fw <= v;
		w(1); fv <= 1'b0;
		w(2); #1;
	endtask
	task rng(input logic [25:0] v);
		for (int i = 0; i < 4; i++) begin
			fp(v);
			if (i < 3)
				`CHK(sw[16], 1'b0)
		end
		`CHK(sw, 24'h070555)
	endtask
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		w(3); #1;
		`CHK(sw & 24'hdfffff, 24'h000000)
		`CHK(en, 1'b1)
		w(1); rst <= 1'b0;
		w(2); #1;
		`CHK(sw[15:0], 16'h0555)
		`CHK(sw[17], 1'b0)
		settle;
		`CHK(sw[17], 1'b1)
		rd(5'h00);
		w(2); #1;
		`CHK(sw, 24'h020555)
		$display("test reset and readback done");
		w(1); fv <= 1'b1; fw <= 26'h1000000;
		w(1); fw <= 26'h37fffff; #1;
		`CHK(rw, 24'h7fffff)
		`CHK(rv, 1'b1)
		w(1); fv <= 1'b0; #1;
		`CHK(rw, 24'h800000)
		w(2); #1;
		`CHK(sw, 24'h8a0555)
		`CHK(en, 1'b0)
		rd(5'h00);
		`CHK(hw, 24'h8a0555)
		w(1); #1;
		`CHK(sw, 24'h020555)
		`CHK(en, 1'b1)
		$display("test saturation done");
		w(1); rl <= 1'b1; ra <= 1'b1;
		w(1); rl <= 1'b0; ra <= 1'b0;
		w(2); #1;
		`CHK(sw, 24'hc20555)
		rd(5'h0a);
		`CHK(sw, 24'hc20555)
		rd(5'h00);
		`CHK(hw, 24'hc20555)
		$display("test overwrite and abort done");
		w(1); sr <= 1'b1;
		rng(26'h0600000);
		rd(5'h00);
		w(2); #1;
		`CHK(sw, 24'h060555)
		rng(26'h39fffff);
		w(1); sr <= 1'b0;
		rd(5'h00);
		w(2); #1;
		`CHK(sw, 24'h020555)
		$display("test range done");
		w(1); sy <= 1'b1;
		w(1); sy <= 1'b0;
		w(2); #1;
		`CHK(sw, 24'h000555)
		fp(26'h1000000);
		`CHK(sw, 24'h000555)
		settle;
		w(1); gs <= 5'h0a;
		w(3); #1;
		`CHK(sw, 24'h00054a)
		settle;
		$display("test settle clears done");
		w(1); mf <= 1'b1;
		w(6); #1;
		`CHK(sw, 24'ha0054a)
		`CHK(en, 1'b0)
		w(1); mf <= 1'b0;
		w(6); #1;
		`CHK(sw, 24'ha0054a)
		w(1); pd <= 1'b1;
		w(3); #1;
		`CHK(sw, 24'ha00d4a)
		rd(5'h00);
		`CHK(hw, 24'ha00d4a)
		w(2); #1;
		`CHK(sw, 24'h000d4a)
		w(1); pd <= 1'b0;
		w(2); #1;
		`CHK(sw, 24'h00054a)
		settle;
		`CHK(sw, 24'h02054a)
		$display("test flag and power-down done");
		w(1); mf <= 1'b1;
		w(6); #1;
		`CHK(sw, 24'ha0054a)
		w(1); rst <= 1'b1;
		w(3); #1;
		`CHK(sw[21], 1'b1)
		`CHK(sw & 24'hdfffff, 24'h000000)
		`CHK(en, 1'b1)
		w(1); rst <= 1'b0; mf <= 1'b0;
		w(3); #1;
		`CHK(sw, 24'ha0054a)
		`CHK(en, 1'b0)
		$display("test mid-run reset done");
		finish_test;
	end
endmodule
